/* hdl/wiper_if_map.vh */
`ifndef WIPER_IF_MAP_VH
`define WIPER_IF_MAP_VH
// Fixed device-type address prefix (six address MSBs), value is arbitrary
`define DEV_TYPE_PREFIX   6'h2d
// Wiper position reset value, midscale code 128
`define WIPER_RESET       8'h80
// Center tap code loaded by the center tap reset bit
`define WIPER_CENTER      8'h80
// Instruction byte field positions
`define INSTR_CENTER_BIT  6
`define INSTR_OPEN_BIT    5
// Bit counter values
`define BIT_LAST          4'h7
`define BIT_ACK           4'h8
// Top open bit reset value
`define OPEN_RESET        1'b0
`endif

/* hdl/wiper_if.v */
`timescale 1ns/1ps
// What this block does
// R1: Wiper register resets to midscale code 128
// R2: 8-bit wiper decoded one-hot to 256 taps
// R3: Code zero selects bottom tap, upward
// R4: Master starts transfers only on idle bus
// R5: Data change during clock high is START/STOP
// R6: Master drives clock; device is slave only
// R7: SDA falling with SCL high is START
// R8: Ignore bus, drive nothing until START
// R9: SDA rising with SCL high is STOP
// R10: Master ends every operation with STOP
// R11: Compare six address MSBs with fixed prefix
// R12: Seventh address bit compared with select pin
// R13: Acknowledge a matching address byte
// R14: Receiver pulls data low on ninth clock
// R15: Acknowledge every written byte after address
// R16: Read shifts eight bits MSB first, samples ack
// R17: Master ack means send another byte
// R18: Master no-ack: release line, await STOP
// R19: Eighth address bit selects write or read
// R20: Write three bytes, read two bytes
// R21: Instruction bit six moves wiper to center
// R22: Instruction bit five opens top, grounds wiper
// R23: Address mismatch: no ack, ignore until START
// R24: Read data is current wiper register
`include "wiper_if_map.vh"

module wiper_if (
  input  wire         sys_clk,
  input  wire         reset,
  input  wire         scl_in,
  input  wire         sda_in,
  input  wire         addr_select_pin,
  output reg          sda_out,
  output reg          sda_oe,
  output reg  [255:0] tap_select,
  output reg          top_open,
  output reg  [7:0]   wiper_position
);

  ////////////////////////////////////////////////////////////////////////////
  // States
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_ADDR  = 5'h02;
  localparam [4:0] ST_WRITE = 5'h04;
  localparam [4:0] ST_READ  = 5'h08;
  localparam [4:0] ST_WAIT  = 5'h10;

  reg  [4:0] state_r;
  reg        scl_q_r;
  reg        sda_q_r;
  reg  [3:0] bit_cnt_r;
  reg  [7:0] shift_r;
  reg  [1:0] byte_cnt_r;
  reg        ack_slot_r;
  reg  [7:0] tx_r;
  reg        open_r;
  wire       start_det;
  wire       stop_det;
  wire       scl_rise;
  wire       scl_fall;
  wire [7:0] rx_byte;
  wire       addr_ok;
  wire [255:0] tap_dec;

  ////////////////////////////////////////////////////////////////////////////
  // Bus condition detection
  assign start_det = scl_in && scl_q_r && sda_q_r && !sda_in; // [R5] [R7]
  assign stop_det  = scl_in && scl_q_r && !sda_q_r && sda_in; // [R5] [R9]
  assign scl_rise  = scl_in && !scl_q_r;
  assign scl_fall  = !scl_in && scl_q_r;
  assign rx_byte   = {shift_r[6:0], sda_in};
  assign addr_ok   = (rx_byte[7:2] == `DEV_TYPE_PREFIX) &&   // [R11]
                     (rx_byte[1] == addr_select_pin);        // [R12]

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r        <= ST_IDLE;
      bit_cnt_r      <= 4'h0;
      shift_r        <= 8'h00;
      byte_cnt_r     <= 2'h0;
      ack_slot_r     <= 1'b0;
      tx_r           <= 8'h00;
      sda_out        <= 1'b0;
      sda_oe         <= 1'b0;
      wiper_position <= `WIPER_RESET;                        // [R1]
      open_r         <= `OPEN_RESET;
    end else if (start_det) begin
      state_r    <= ST_ADDR;
      bit_cnt_r  <= 4'h0;
      byte_cnt_r <= 2'h0;
      ack_slot_r <= 1'b0;
      sda_oe     <= 1'b0;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      sda_oe  <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          sda_oe <= 1'b0;                                    // [R8]
        end
        ST_ADDR, ST_WRITE: begin
          if (scl_rise && !ack_slot_r) begin
            shift_r <= rx_byte;
            if (bit_cnt_r == `BIT_LAST) begin
              if (state_r == ST_ADDR && !addr_ok) begin
                state_r <= ST_WAIT;                          // [R23]
              end else begin
                ack_slot_r <= 1'b1;
                if (state_r == ST_ADDR) begin
                  state_r <= rx_byte[0] ? ST_READ : ST_WRITE; // [R19]
                  tx_r    <= wiper_position;                 // [R24]
                end else if (byte_cnt_r == 2'h1) begin
                  open_r <= rx_byte[`INSTR_OPEN_BIT];        // [R22]
                  if (rx_byte[`INSTR_CENTER_BIT]) begin
                    wiper_position <= `WIPER_CENTER;         // [R21]
                  end
                end else if (byte_cnt_r == 2'h2) begin
                  wiper_position <= rx_byte;                 // [R20]
                end
                // Bytes after the data byte are acked and dropped
                if (byte_cnt_r != 2'h3) begin
                  byte_cnt_r <= byte_cnt_r + 2'h1;           // [R15]
                end
              end
              bit_cnt_r <= 4'h0;
            end else begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
          if (scl_fall && ack_slot_r) begin
            if (!sda_oe) begin
              sda_oe  <= 1'b1;                               // [R13] [R14] [R15]
              sda_out <= 1'b0;
            end else begin
              sda_oe     <= 1'b0;
              ack_slot_r <= 1'b0;
            end
          end
        end
        ST_READ: begin
          // Address ack, then first data bit
          if (ack_slot_r) begin
            if (scl_fall) begin
              if (!sda_oe) begin
                sda_oe  <= 1'b1;                             // [R13] [R14]
                sda_out <= 1'b0;
              end else begin
                ack_slot_r <= 1'b0;
                sda_out    <= tx_r[7];                       // [R16]
                tx_r       <= {tx_r[6:0], 1'b0};
              end
            end
          end else begin
            // Data bits, then master ack on the ninth clock
            if (scl_rise) begin
              if (bit_cnt_r == `BIT_ACK) begin
                bit_cnt_r <= 4'h0;
                if (sda_in) begin
                  state_r <= ST_WAIT;                        // [R18]
                end else begin
                  tx_r <= wiper_position;                    // [R17] [R24]
                end
              end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
            if (scl_fall) begin
              if (bit_cnt_r == `BIT_ACK) begin
                sda_oe <= 1'b0;                              // [R16]
              end else begin
                sda_oe  <= 1'b1;                             // [R16] [R17]
                sda_out <= tx_r[7];
                tx_r    <= {tx_r[6:0], 1'b0};
              end
            end
          end
        end
        ST_WAIT: begin
          sda_oe <= 1'b0;                                    // [R18] [R23]
        end
        default: begin
          state_r <= ST_IDLE;
          sda_oe  <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tap decode
  genvar gi;
  generate
    for (gi = 0; gi < 256; gi = gi + 1) begin : g_tap
      assign tap_dec[gi] = ({24'h000000, wiper_position} == gi); // [R2] [R3]
    end
  endgenerate

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tap_select <= 256'h0;
      top_open   <= 1'b0;
    end else begin
      tap_select <= open_r ? {255'h0, 1'b1} : tap_dec;       // [R2] [R22]
      top_open   <= open_r;                                  // [R22]
    end
  end

endmodule // wiper_if

/* verif/wiper_if_props.sv */
`timescale 1ns/1ps
module wiper_if_props (
  input wire         sys_clk,
  input wire         reset,
  input wire         scl_in,
  input wire         sda_in,
  input wire         addr_select_pin,
  input wire         sda_out,
  input wire         sda_oe,
  input wire [255:0] tap_select,
  input wire         top_open,
  input wire [7:0]   wiper_position
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_tap_onehot:
    assert property (!$past(reset) |-> $onehot(tap_select)) else $error("tap not one-hot");
  chk_tap_follow:
    assert property (!top_open [*3] ##0 $stable(wiper_position)
      |-> tap_select == (256'h1 << wiper_position)) else $error("tap off wiper");
  chk_open_tap:
    assert property (top_open [*3] |-> tap_select == 256'h1) else $error("open tap");
  chk_open_keeps:
    assert property ($rose(top_open) |-> $stable(wiper_position)) else $error("open moved wiper");
  chk_drive_low:
    assert property ($changed(sda_oe) || (sda_oe && $changed(sda_out)) |-> !scl_in)
      else $error("data changed in clock high");
  chk_oe_bound:
    assert property ($rose(sda_oe) |-> ##[1:90] !sda_oe) else $error("line held too long");
  chk_wiper_edge:
    assert property ($changed(wiper_position) |-> scl_in) else $error("wiper moved off edge");
  chk_stop_free:
    assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:4] !sda_oe)
      else $error("drive after stop");
endmodule // wiper_if_props
bind wiper_if wiper_if_props u_props (.sys_clk(sys_clk), .reset(reset), .scl_in(scl_in),
  .sda_in(sda_in), .addr_select_pin(addr_select_pin), .sda_out(sda_out), .sda_oe(sda_oe),
  .tap_select(tap_select), .top_open(top_open), .wiper_position(wiper_position));

/* verif/i2c_master_model.sv */
`timescale 1ns/1ps
module i2c_master_model (
  input  wire sys_clk,
  input  wire sda,
  output reg  scl,
  output reg  sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task ph(input logic c, input logic d);
    @(posedge sys_clk);
    scl <= c;
    sda_m <= d;
    repeat (2) @(posedge sys_clk);
  endtask
  task start;
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  task stop;
    ph(1'b0, sda_m);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // Nine bits, MSB first, data steady in clock high; 1 releases the line
  task xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, sda_m);
      ph(1'b0, d[i]);
      ph(1'b1, d[i]);
      r[i] = sda;
    end
  endtask
endmodule // i2c_master_model

/* verif/test_wiper_if.sv */
`timescale 1ns/1ps
`include "wiper_if_map.vh"
module test_wiper_if;
  logic         sys_clk = 1'b0;
  logic         reset = 1'b1;
  logic         strap = 1'b0;
  wire          scl, sda_m, sda_out, sda_oe, top_open;
  wire  [255:0] tap_select;
  wire  [7:0]   wiper_position;
  wire          sda = sda_m & ~(sda_oe & ~sda_out);
  integer       errors = 0, samples_checked = 0, seed = 95, cyc = 0;
  logic [8:0]   r;
  logic [7:0]   w, d;
  always #50 sys_clk = ~sys_clk;
  wiper_if u_dut (.sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .addr_select_pin(strap), .sda_out(sda_out), .sda_oe(sda_oe), .tap_select(tap_select),
    .top_open(top_open), .wiper_position(wiper_position));
  i2c_master_model u_m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  function automatic logic [255:0] exp_tap(input logic [7:0] v, input logic o);
    return o ? 256'h1 : (256'h1 << v);
  endfunction
  task chk(input string n, input logic [255:0] e, input logic [255:0] g);
    samples_checked++;
    if (e !== g) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task stop_test;
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] ins, input logic [7:0] dat, input int n);
    logic m;
    m = (a[7:1] == {`DEV_TYPE_PREFIX, strap});
    u_m.start;
    u_m.xfer({a, 1'b1}, r);
    chk("addr ack", !m, r[0]);
    if (n > 1) u_m.xfer({ins, 1'b1}, r);
    if (n > 1) chk("ins ack", !m, r[0]);
    if (n > 2) u_m.xfer({dat, 1'b1}, r);
    if (n > 2) chk("data ack", !m, r[0]);
    u_m.stop;
  endtask
  task rd(input int n);
    u_m.start;
    u_m.xfer({`DEV_TYPE_PREFIX, strap, 1'b1, 1'b1}, r);
    chk("read ack", 1'b0, r[0]);
    for (int k = 0; k < n; k++) begin
      u_m.xfer({8'hff, k == n - 1}, r);
      chk("read data", w, r[8:1]);
    end
    u_m.stop;
    chk("released", 1'b0, sda_oe);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    strap <= 1'($random(seed));
    repeat (3) @(posedge sys_clk);
    chk("wiper reset", `WIPER_RESET, wiper_position);
    chk("tap reset", exp_tap(8'h80, 1'b0), tap_select);
    w = 8'h80;
    for (int k = 0; k < 8; k++) begin
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
      wr({`DEV_TYPE_PREFIX, strap, 1'b0}, {k[0], 7'h00}, d, 3);
      w = d;
      chk("wiper", w, wiper_position);
      chk("tap", exp_tap(w, 1'b0), tap_select);
      rd(2);
    end
    $display("Write and read test done");
    wr({`DEV_TYPE_PREFIX, strap, 1'b0}, 8'h40, 8'h00, 2);
    w = `WIPER_CENTER;
    chk("center", w, wiper_position);
    d = 8'($random(seed));
    wr({`DEV_TYPE_PREFIX, strap, 1'b0}, 8'h20, d, 3);
    w = d;
    chk("open", 1'b1, top_open);
    chk("open tap", exp_tap(w, 1'b1), tap_select);
    rd(1);
    wr({`DEV_TYPE_PREFIX, strap, 1'b0}, 8'h00, d, 3);
    chk("closed tap", exp_tap(w, 1'b0), tap_select);
    $display("Instruction test done");
    wr({`DEV_TYPE_PREFIX, ~strap, 1'b0}, 8'h00, 8'h11, 3);
    wr({6'h15, strap, 1'b0}, 8'h00, 8'h22, 3);
    chk("ignored", w, wiper_position);
    $display("Address test done");
    stop_test;
  end
endmodule // test_wiper_if
